// File: shared/setup_regs_pkg.sv
// Register offsets, field positions and types of the triangle setup register bank
package setup_regs_pkg;
  // Word indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_CORNER_BASE = 8'h02;
  localparam logic [7:0] IDX_SEED_RED = 8'h08;
  localparam logic [7:0] IDX_RED_STEP = 8'h09;
  localparam logic [7:0] IDX_SEED_GREEN = 8'h0b;
  localparam logic [7:0] IDX_GREEN_STEP = 8'h0c;
  localparam logic [7:0] IDX_SEED_BLUE = 8'h0e;
  localparam logic [7:0] IDX_BLUE_STEP = 8'h0f;
  localparam logic [7:0] IDX_SEED_DEPTH = 8'h11;
  localparam logic [7:0] IDX_DEPTH_STEP = 8'h12;
  localparam logic [7:0] IDX_SEED_ALPHA = 8'h14;
  localparam logic [7:0] IDX_ALPHA_STEP = 8'h15;
  localparam logic [7:0] IDX_SEED_TEX_S = 8'h17;
  localparam logic [7:0] IDX_SEED_TEX_T = 8'h1a;
  localparam logic [7:0] IDX_SEED_INV_W = 8'h1d;
  localparam logic [7:0] IDX_TRIANGLE = 8'h20;
  localparam logic [7:0] IDX_FLOAT_OFFSET = 8'h20;
  localparam logic [7:0] IDX_BUFFER_FLIP = 8'h46;
  localparam logic [7:0] IDX_FLIP_PENDING = 8'h48;
  localparam logic [7:0] IDX_GENERAL_INIT = 8'h90;
  localparam logic [7:0] IDX_QUEUE_INIT = 8'h92;
  localparam logic [7:0] IDX_PIXEL_STEP = 8'hf0;
  localparam logic [7:0] IDX_SETUP_READBACK = 8'hf1;
  localparam logic [7:0] IDX_ACCUM_BASE = 8'hf8;
  // Status fields
  localparam int STAT_FRAME_BUSY = 0;
  localparam int STAT_TEX_BUSY = 1;
  localparam int STAT_FLIP_REQ = 2;
  localparam int STAT_SYNC = 3;
  localparam int STAT_PEND_LO = 4;
  localparam int STAT_QFULL = 7;
  localparam int STAT_FREE_LO = 8;
  localparam int STAT_CMD_OVF = 14;
  localparam int STAT_MEM_OVF = 15;
  localparam logic [2:0] PEND_MAX = 3'h7;
  // Queue-setup init fields, 6 bits each
  localparam int QI_THRESH_LO = 0;
  localparam int QI_BOTTOM_LO = 6;
  localparam int QI_TOP_LO = 12;
  localparam int GI_SYNC_INVERT = 0;
  localparam logic [31:0] GENERAL_INIT_RESET = 32'h0;
  localparam logic [31:0] QUEUE_INIT_RESET = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Internal fixed-point forms: 12.4 coordinates, 12.12 colour, 20.12 depth, 14.18 tex, 2.30 inverse W
  localparam int COORD_FRAC = 4;
  localparam int COLOR_FRAC = 12;
  localparam int DEPTH_FRAC = 12;
  localparam int TEX_FRAC = 18;
  localparam int INVW_FRAC = 30;

  typedef struct packed {
    logic frameBusy;
    logic texBusy;
    logic flipDone;
    logic vsyncRaw;
    logic [5:0] memFree;
    logic memPush;
    logic [5:0] cmdEntries;
  } engine_state_s;

  typedef struct packed {
    logic triangleStart;
    logic flipRequest;
    logic softReset;
  } engine_ctrl_s;
endpackage

// File: logic/triangle_setup_status_regs.sv
// AXI4-Lite register bank: engine status word and triangle setup registers
//
// Operation
// - Bit 0 reads frame engine busy.
// - Bit 1 reads texture engine busy.
// - Bit 2 flip request, one per flip.
// - Bit 3 mirrors selected vertical sync.
// - Bits 6:4 count pending flips.
// - Pending count saturates at 7 and 0.
// - Bit 7 queue count at/above threshold.
// - Bits 13:8 memory queue free space.
// - Bit 14 set on command queue overflow.
// - Bit 15 set on push when full.
// - Overflow bits sticky until hard/soft reset.
// - Fixed coordinates are 12.4 in 15:0.
// - Float registers converted to fixed form.
// - Colour seeds are 12.12 in 23:0.
// - S/W, T/W, 1/W loaded but not stepped.
// - Inverse W seed is 2.30.
// - Colour gradients added right, subtracted left.
// - Status word is read-only.
// - Triangle command seeds accumulators with loaded setup.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module triangle_setup_status_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire setup_regs_pkg::engine_state_s engineState,
  input wire logic vsyncPin,
  output setup_regs_pkg::engine_ctrl_s engineCtrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Float to fixed conversion, truncating toward zero, saturating on overflow

  function automatic logic [31:0] float_to_fixed(input logic [31:0] f, input int frac, input int width);
    logic [31:0] mag;
    logic [63:0] wide;
    int sh;
    mag = 32'h0;
    wide = {40'h0, 1'b1, f[22:0]};
    sh = int'(f[30:23]) - 127 - 23 + frac;
    if (f[30:23] == 8'h00) begin
      mag = 32'h0;
    end else if (sh >= 0) begin
      if (sh > width - 1) begin
        mag = 32'hffffffff >> (33 - width);
      end else begin
        wide = wide << sh;
        mag = (wide[63:32] != 32'h0 || wide[31:0] > (32'hffffffff >> (33 - width))) ?
              (32'hffffffff >> (33 - width)) : wide[31:0];
      end
    end else if (sh > -25) begin
      wide = wide >> (-sh);
      mag = wide[31:0];
    end
    float_to_fixed = f[31] ? (~mag + 32'h1) : mag;
  endfunction

  function automatic logic [31:0] sign24(input logic [23:0] v);
    sign24 = {{8{v[23]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Inputs from outside the domain: two flip-flops each

  setup_regs_pkg::engine_state_s stateMeta_q, stateSync_q;
  logic vsyncMeta_q, vsyncSync_q;
  logic memPushPrev_q, flipDonePrev_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateMeta_q <= '0;
      stateSync_q <= '0;
      vsyncMeta_q <= 1'b0;
      vsyncSync_q <= 1'b0;
      memPushPrev_q <= 1'b0;
      flipDonePrev_q <= 1'b0;
    end else begin
      stateMeta_q <= engineState;
      stateSync_q <= stateMeta_q;
      vsyncMeta_q <= vsyncPin;
      vsyncSync_q <= vsyncMeta_q;
      memPushPrev_q <= stateSync_q.memPush;
      flipDonePrev_q <= stateSync_q.flipDone;
    end
  end

  // Push and flip completion are levels that toggle per event, so the crossing stays lossless
  logic memPushEvt, flipDoneEvt;
  assign memPushEvt = stateSync_q.memPush ^ memPushPrev_q;
  assign flipDoneEvt = stateSync_q.flipDone ^ flipDonePrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order

  logic [9:0] awAddr_q;
  logic awHeld_q, wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic doWrite;
  logic [7:0] wIdx;
  logic wMapped;

  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wIdx = awAddr_q[9:2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awAddr_q <= 10'h0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= setup_regs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= wMapped ? setup_regs_pkg::RESP_OKAY : setup_regs_pkg::RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Setup storage: one internal fixed value per parameter, shared by both forms

  // Parameter slots: 0..5 corners, 6..9 colour seeds, 10..13 colour steps,
  // 14 depth seed, 15 depth step, 16 tex S, 17 tex T, 18 inverse W
  localparam int NSLOT = 19;
  logic [31:0] slot_q [NSLOT];
  logic [31:0] wMerged;
  logic slotHit;
  logic slotFloat;
  int slotNum;
  logic [31:0] slotValue;

  assign wMerged = {wStrb_q[3] ? wData_q[31:24] : 8'h0, wStrb_q[2] ? wData_q[23:16] : 8'h0,
                    wStrb_q[1] ? wData_q[15:8] : 8'h0, wStrb_q[0] ? wData_q[7:0] : 8'h0};

  always_comb begin
    logic [7:0] base;
    slotHit = 1'b1;
    slotNum = 0;
    slotFloat = wIdx >= setup_regs_pkg::IDX_TRIANGLE + 8'h2 && wIdx < setup_regs_pkg::IDX_TRIANGLE + 8'h20;
    base = slotFloat ? wIdx - setup_regs_pkg::IDX_FLOAT_OFFSET : wIdx;
    unique case (base)
      8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07: slotNum = int'(base - setup_regs_pkg::IDX_CORNER_BASE);
      setup_regs_pkg::IDX_SEED_RED: slotNum = 6;
      setup_regs_pkg::IDX_SEED_GREEN: slotNum = 7;
      setup_regs_pkg::IDX_SEED_BLUE: slotNum = 8;
      setup_regs_pkg::IDX_SEED_ALPHA: slotNum = 9;
      setup_regs_pkg::IDX_RED_STEP: slotNum = 10;
      setup_regs_pkg::IDX_GREEN_STEP: slotNum = 11;
      setup_regs_pkg::IDX_BLUE_STEP: slotNum = 12;
      setup_regs_pkg::IDX_ALPHA_STEP: slotNum = 13;
      setup_regs_pkg::IDX_SEED_DEPTH: slotNum = 14;
      setup_regs_pkg::IDX_DEPTH_STEP: slotNum = 15;
      setup_regs_pkg::IDX_SEED_TEX_S: slotNum = 16;
      setup_regs_pkg::IDX_SEED_TEX_T: slotNum = 17;
      setup_regs_pkg::IDX_SEED_INV_W: slotNum = 18;
      default: slotHit = 1'b0;
    endcase
    slotValue = wMerged;
    if (slotNum < 6) begin
      slotValue = slotFloat ? float_to_fixed(wData_q, setup_regs_pkg::COORD_FRAC, 16)
                            : {{16{wMerged[15]}}, wMerged[15:0]};
    end else if (slotNum < 14) begin
      slotValue = slotFloat ? float_to_fixed(wData_q, setup_regs_pkg::COLOR_FRAC, 24)
                            : sign24(wMerged[23:0]);
    end else if (slotNum < 16) begin
      slotValue = slotFloat ? float_to_fixed(wData_q, setup_regs_pkg::DEPTH_FRAC, 32) : wMerged;
    end else if (slotNum < 18) begin
      slotValue = slotFloat ? float_to_fixed(wData_q, setup_regs_pkg::TEX_FRAC, 32) : wMerged;
    end else begin
      slotValue = slotFloat ? float_to_fixed(wData_q, setup_regs_pkg::INVW_FRAC, 32) : wMerged;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_q[i] <= 32'h0;
      end
    end else if (doWrite && slotHit) begin
      slot_q[slotNum] <= slotValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and command strobes

  logic [31:0] generalInit_q, queueInit_q;
  logic isGeneral, isQueue, isFlip, isPend, isTri, isStep, isStatus;
  assign isGeneral = wIdx == setup_regs_pkg::IDX_GENERAL_INIT;
  assign isQueue = wIdx == setup_regs_pkg::IDX_QUEUE_INIT;
  assign isFlip = wIdx == setup_regs_pkg::IDX_BUFFER_FLIP;
  assign isPend = wIdx == setup_regs_pkg::IDX_FLIP_PENDING;
  assign isTri = wIdx == setup_regs_pkg::IDX_TRIANGLE || wIdx == setup_regs_pkg::IDX_TRIANGLE + 8'h20;
  assign isStep = wIdx == setup_regs_pkg::IDX_PIXEL_STEP;
  assign isStatus = wIdx == setup_regs_pkg::IDX_STATUS;
  // Status accepts the write but ignores it, so software gets OKAY and nothing changes
  assign wMapped = slotHit || isGeneral || isQueue || isFlip || isPend || isTri || isStep || isStatus;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      generalInit_q <= setup_regs_pkg::GENERAL_INIT_RESET;
      queueInit_q <= setup_regs_pkg::QUEUE_INIT_RESET;
    end else if (doWrite && isGeneral) begin
      generalInit_q <= wMerged;
    end else if (doWrite && isQueue) begin
      queueInit_q <= wMerged;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      engineCtrl <= '0;
    end else begin
      engineCtrl.triangleStart <= doWrite && isTri;
      engineCtrl.flipRequest <= doWrite && isFlip;
      engineCtrl.softReset <= doWrite && isGeneral && wMerged[31];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word sources

  logic softReset;
  logic flipReq_q;
  logic [2:0] pendCount_q;
  logic cmdOvf_q, memOvf_q;
  logic pendInc;
  logic [5:0] qThresh, qBottom, qTop, qSpace;
  assign softReset = engineCtrl.softReset;
  assign pendInc = doWrite && isPend;
  assign qThresh = queueInit_q[setup_regs_pkg::QI_THRESH_LO +: 6];
  assign qBottom = queueInit_q[setup_regs_pkg::QI_BOTTOM_LO +: 6];
  assign qTop = queueInit_q[setup_regs_pkg::QI_TOP_LO +: 6];
  assign qSpace = qTop - qBottom;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flipReq_q <= 1'b0;
    end else if (doWrite && isFlip) begin
      flipReq_q <= 1'b1;
    end else if (flipDoneEvt) begin
      flipReq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pendCount_q <= 3'h0;
    end else if (pendInc && !flipDoneEvt && pendCount_q != setup_regs_pkg::PEND_MAX) begin
      pendCount_q <= pendCount_q + 3'h1;
    end else if (flipDoneEvt && !pendInc && pendCount_q != 3'h0) begin
      pendCount_q <= pendCount_q - 3'h1;
    end
  end

  // Set wins over soft reset so an overflow in the clearing cycle is kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdOvf_q <= 1'b0;
      memOvf_q <= 1'b0;
    end else begin
      cmdOvf_q <= (stateSync_q.cmdEntries > qSpace) || (cmdOvf_q && !softReset);
      memOvf_q <= (memPushEvt && stateSync_q.memFree == 6'h0) || (memOvf_q && !softReset);
    end
  end

  logic [15:0] statusWord;
  always_comb begin
    statusWord = 16'h0;
    statusWord[setup_regs_pkg::STAT_FRAME_BUSY] = stateSync_q.frameBusy;
    statusWord[setup_regs_pkg::STAT_TEX_BUSY] = stateSync_q.texBusy;
    statusWord[setup_regs_pkg::STAT_FLIP_REQ] = flipReq_q;
    statusWord[setup_regs_pkg::STAT_SYNC] = vsyncSync_q ^ generalInit_q[setup_regs_pkg::GI_SYNC_INVERT];
    statusWord[setup_regs_pkg::STAT_PEND_LO +: 3] = pendCount_q;
    statusWord[setup_regs_pkg::STAT_QFULL] = stateSync_q.cmdEntries >= qThresh;
    statusWord[setup_regs_pkg::STAT_FREE_LO +: 6] = stateSync_q.memFree;
    statusWord[setup_regs_pkg::STAT_CMD_OVF] = cmdOvf_q;
    statusWord[setup_regs_pkg::STAT_MEM_OVF] = memOvf_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel stepper: colour, depth, S/W, T/W and 1/W accumulators

  // Accumulators: 0..3 colour, 4 depth, 5 S/W, 6 T/W, 7 1/W
  logic [31:0] accum_q [8];
  logic [31:0] stepOf [8];
  logic stepGo, stepLeft;
  assign stepGo = doWrite && isStep;
  assign stepLeft = wMerged[0];

  // S, T and 1/W X-gradients are not in this bank; they hold still here
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      stepOf[i] = slot_q[10 + i];
    end
    stepOf[4] = slot_q[15];
    stepOf[5] = 32'h0;
    stepOf[6] = 32'h0;
    stepOf[7] = 32'h0;
  end

  generate
    for (genvar g = 0; g < 8; g++) begin : g_accum
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          accum_q[g] <= 32'h0;
        end else if (doWrite && isTri) begin
          accum_q[g] <= (g < 4) ? slot_q[6 + g] : (g == 4) ? slot_q[14] : slot_q[11 + g];
        end else if (stepGo) begin
          accum_q[g] <= stepLeft ? accum_q[g] - stepOf[g] : accum_q[g] + stepOf[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic [7:0] rIdx;
  assign rIdx = s_axi_araddr[9:2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h0;
      rResp_q <= setup_regs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rResp_q <= setup_regs_pkg::RESP_OKAY;
      if (rIdx == setup_regs_pkg::IDX_STATUS) begin
        rData_q <= {16'h0, statusWord};
      end else if (rIdx == setup_regs_pkg::IDX_GENERAL_INIT) begin
        rData_q <= generalInit_q;
      end else if (rIdx == setup_regs_pkg::IDX_QUEUE_INIT) begin
        rData_q <= queueInit_q;
      end else if (rIdx >= setup_regs_pkg::IDX_ACCUM_BASE) begin
        rData_q <= accum_q[rIdx[2:0]];
      end else begin
        rData_q <= 32'h0;
        rResp_q <= setup_regs_pkg::RESP_SLVERR;
      end
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

endmodule
`default_nettype wire

// File: dv/triangle_setup_status_regs_monitor.sv
// Port-level assertions for the triangle setup and status register bank
`timescale 1ns/100ps
`default_nettype none
module triangle_setup_status_regs_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire setup_regs_pkg::engine_state_s engineState,
  input wire logic vsyncPin,
  input wire setup_regs_pkg::engine_ctrl_s engineCtrl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  localparam logic [9:0] FLIP_ADDR = {setup_regs_pkg::IDX_BUFFER_FLIP, 2'b00};
  localparam logic [9:0] TRI_ADDR = {setup_regs_pkg::IDX_TRIANGLE, 2'b00};
  localparam logic [9:0] INIT_ADDR = {setup_regs_pkg::IDX_GENERAL_INIT, 2'b00};
  logic wrBoth;
  logic rdTake;
  assign wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rdTake = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////////////////////////////////////////////////////
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("bvalid dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("rvalid dropped");
  property p_aw_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refused: assert property (p_aw_refused)
    else $error("write taken while response pending");
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused)
    else $error("read taken while data pending");
  property p_write_answer;
    wrBoth |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("no write response");
  property p_status_read;
    rdTake && s_axi_araddr == 10'h000 |-> ##[1:2] s_axi_rvalid && s_axi_rresp == setup_regs_pkg::RESP_OKAY;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read not OKAY");
  property p_flip_request;
    wrBoth && s_axi_awaddr == FLIP_ADDR |-> ##[1:4] engineCtrl.flipRequest;
  endproperty
  a_flip_request: assert property (p_flip_request)
    else $error("flip write gave no request");
  property p_flip_single;
    $rose(engineCtrl.flipRequest) |=> !engineCtrl.flipRequest;
  endproperty
  a_flip_single: assert property (p_flip_single)
    else $error("flip request too long");
  property p_tri_start;
    wrBoth && s_axi_awaddr == TRI_ADDR |-> ##[1:4] engineCtrl.triangleStart;
  endproperty
  a_tri_start: assert property (p_tri_start)
    else $error("triangle write gave no start");
  property p_soft_reset;
    wrBoth && s_axi_awaddr == INIT_ADDR && s_axi_wdata[31] |-> ##[1:4] engineCtrl.softReset;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset write gave no pulse");
  c_flip: cover property (engineCtrl.flipRequest);
  c_tri: cover property (engineCtrl.triangleStart);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == setup_regs_pkg::RESP_SLVERR);
endmodule
bind triangle_setup_status_regs triangle_setup_status_regs_monitor mon_u (.*);
`default_nettype wire

// File: dv/tb_triangle_setup_status_regs.sv
// Self-checking bench for the triangle setup and status register bank
`timescale 1ns/100ps
`default_nettype none
module tb_triangle_setup_status_regs;
  logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, vsyncPin;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  setup_regs_pkg::engine_state_s engineState;
  setup_regs_pkg::engine_ctrl_s engineCtrl;
  int miscompares = 0;
  int check_count = 0;
  triangle_setup_status_regs dut_u (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Handshakes sampled mid-cycle, after ready settles
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er, input int dly = 0);
    bit ha, hw, hb;
    int n;
    logic [1:0] rs;
    hb = 0;
    n = 0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (dly == 0);
    while (!hb && n < 200) begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clk);
      n++;
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !hb && n >= dly;
    end
    if (!hb) miscompares++;
    chk("bresp", {30'h0, rs}, {30'h0, er});
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r, input int dly = 0);
    bit ha, hr;
    int n;
    hr = 0;
    n = 0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (dly == 0);
    while (!hr && n < 200) begin
      @(negedge clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      n++;
      if (ha) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !hr && n >= dly;
    end
    if (!hr) miscompares++;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(nm, d & m, e);
    chk("rresp", {30'h0, r}, {30'h0, setup_regs_pkg::RESP_OKAY});
  endtask
  // Let inputs cross the two-flop synchroniser
  task automatic st(input logic [15:0] e);
    repeat (5) @(posedge clk);
    rdc("status", setup_regs_pkg::IDX_STATUS, {16'h0, e}, 32'h0000ffff);
  endtask
  task automatic acc(input int k, input logic [31:0] e, input logic [31:0] m);
    rdc("accumulator", setup_regs_pkg::IDX_ACCUM_BASE + 8'(k), e, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    int i;
    logic [2:0] c;
    logic [31:0] dv;
    logic [1:0] rv;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, vsyncPin} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    engineState = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Sync and fullness depend on init values
    rdc("status", setup_regs_pkg::IDX_STATUS, 32'h0, 32'hff77);
    // Threshold 10, bottom 0, top 40
    wr(setup_regs_pkg::IDX_QUEUE_INIT, 32'h0002800a, setup_regs_pkg::RESP_OKAY);
    engineState.frameBusy <= 1'b1;
    st(16'h0001);
    engineState.frameBusy <= 1'b0;
    engineState.texBusy <= 1'b1;
    st(16'h0002);
    engineState.texBusy <= 1'b0;
    vsyncPin <= 1'b1;
    st(16'h0008);
    wr(setup_regs_pkg::IDX_GENERAL_INIT, 32'h1, setup_regs_pkg::RESP_OKAY);
    st(16'h0000);
    vsyncPin <= 1'b0;
    st(16'h0008);
    wr(setup_regs_pkg::IDX_GENERAL_INIT, 32'h0, setup_regs_pkg::RESP_OKAY);
    engineState.memFree <= 6'h3f;
    engineState.cmdEntries <= 6'h0a;
    st(16'h3f80);
    engineState.cmdEntries <= 6'h09;
    st(16'h3f00);
    wr(setup_regs_pkg::IDX_STATUS, 32'hffffffff, setup_regs_pkg::RESP_OKAY);
    st(16'h3f00);
    $display("test status levels finished");
    for (i = 1; i <= 8; i++) begin
      wr(setup_regs_pkg::IDX_FLIP_PENDING, 32'h0, setup_regs_pkg::RESP_OKAY);
      c = (i > 7) ? 3'h7 : 3'(i);
      st({8'h3f, 1'b0, c, 4'h0});
    end
    wr(setup_regs_pkg::IDX_BUFFER_FLIP, 32'h0, setup_regs_pkg::RESP_OKAY, 3);
    st(16'h3f74);
    for (i = 1; i <= 8; i++) begin
      engineState.flipDone <= ~engineState.flipDone;
      c = (i < 7) ? 3'(7 - i) : 3'h0;
      st({8'h3f, 1'b0, c, 4'h0});
    end
    $display("test flip count finished");
    engineState.cmdEntries <= 6'h28;
    st(16'h3f80);
    engineState.cmdEntries <= 6'h29;
    st(16'h7f80);
    engineState.cmdEntries <= 6'h00;
    st(16'h7f00);
    engineState.memFree <= 6'h00;
    engineState.memPush <= ~engineState.memPush;
    st(16'hc000);
    engineState.memFree <= 6'h05;
    st(16'hc500);
    wr(setup_regs_pkg::IDX_GENERAL_INIT, 32'h80000000, setup_regs_pkg::RESP_OKAY);
    st(16'h0500);
    wr(setup_regs_pkg::IDX_GENERAL_INIT, 32'h0, setup_regs_pkg::RESP_OKAY);
    $display("test overflow finished");
    rd(setup_regs_pkg::IDX_SEED_RED, dv, rv, 3);
    chk("setup read resp", {30'h0, rv}, {30'h0, setup_regs_pkg::RESP_SLVERR});
    rd(8'h21, dv, rv);
    chk("unmapped read resp", {30'h0, rv}, {30'h0, setup_regs_pkg::RESP_SLVERR});
    wr(8'h21, 32'h1, setup_regs_pkg::RESP_SLVERR);
    $display("test bus errors finished");
    wr(setup_regs_pkg::IDX_SEED_RED, 32'h00001800, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_RED_STEP, 32'h00fffc00, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_SEED_DEPTH, 32'h00012000, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_DEPTH_STEP, 32'hfffff000, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_TRIANGLE, 32'h0, setup_regs_pkg::RESP_OKAY);
    acc(0, 32'h001800, 32'hffffff);
    wr(setup_regs_pkg::IDX_PIXEL_STEP, 32'h0, setup_regs_pkg::RESP_OKAY);
    acc(0, 32'h001400, 32'hffffff);
    acc(4, 32'h00011000, 32'hffffffff);
    wr(setup_regs_pkg::IDX_PIXEL_STEP, 32'h1, setup_regs_pkg::RESP_OKAY);
    acc(0, 32'h001800, 32'hffffff);
    acc(4, 32'h00012000, 32'hffffffff);
    // Float forms: 1.0 red, 2.0 texture S; fixed 0.5 inverse W
    wr(setup_regs_pkg::IDX_SEED_RED + setup_regs_pkg::IDX_FLOAT_OFFSET, 32'h3f800000, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_SEED_TEX_S + setup_regs_pkg::IDX_FLOAT_OFFSET, 32'h40000000, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_SEED_INV_W, 32'h20000000, setup_regs_pkg::RESP_OKAY);
    wr(setup_regs_pkg::IDX_TRIANGLE + setup_regs_pkg::IDX_FLOAT_OFFSET, 32'h0, setup_regs_pkg::RESP_OKAY);
    acc(0, 32'h001000, 32'hffffff);
    acc(5, 32'h00080000, 32'hffffffff);
    acc(7, 32'h20000000, 32'hffffffff);
    $display("test setup values finished");
    report_and_stop;
  end
endmodule
`default_nettype wire
